// ### core/vst_timing.sv
// sync-slave timing control: trigger phases, field length, blanking,
// subcarrier phase reset cadence and luma delay
// assumes REF_CLK is the line-locked pixel clock and sync pins are async
//
// Behaviour
// - sync type field picks per-field, odd/even frame or field-sequence
// - field sequence expects the reference every 4, 8 or 12 fields
// - 11-bit horizontal phase: low byte, top three bits in next byte
// - horizontal phase is measured from the active trigger pin edge
// - a larger horizontal phase shortens all internal timing delays
// - phase 79 puts horizontal sync lead on the trigger edge
// - 5-bit vertical phase in half lines, larger shortens delays
// - blanking from active line inputs, or forced standard interval
// - force-blank bit holds the output at blanking level
// - mode 0: no phase reset, except real-time input when enabled
// - mode 1: phase reset every two lines, or every line for SECAM
// - mode 2 resets every eight fields, mode 3 every four fields
// - luma delayed 0 to 3 clocks against chroma
// - field length code 0: interlaced, 625 or 525 half lines
// - field length code 1: 312 or 262 lines per field
// - field length code 2: 313 or 263 lines per field
// - polarity bit picks falling pin A edge in, active low out; pin B always triggers on its rising edge
// - horizontal source bit takes pin B unless embedded sync
// - direction bit makes pin A an output
module vst_timing (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_N,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    input  wire logic [7:0]             REG_ADDR,
    input  wire logic [7:0]             REG_WDATA,
    output logic      [7:0]             REG_RDATA,
    input  wire logic [1:0]             SYNC_A_TYPE,
    input  wire logic                   SYNC_A_POLARITY,
    input  wire logic                   SYNC_A_DIRECTION,
    input  wire logic                   HORIZ_SOURCE_SELECT,
    input  wire logic                   EMBEDDED_SYNC_MODE,
    input  wire logic                   FIELD_RATE_SELECT,
    input  wire logic                   PAL_SEQUENCE,
    input  wire logic                   SECAM_SELECT,
    input  wire logic                   REALTIME_CONTROL_ENABLE,
    input  wire logic                   REALTIME_CONTROL_INPUT,
    input  wire logic [8:0]             FIRST_ACTIVE_LINE,
    input  wire logic [8:0]             LAST_ACTIVE_LINE,
    input  wire logic                   SYNC_PIN_A_I,
    output logic                        SYNC_PIN_A_O,
    output logic                        SYNC_PIN_A_OE,
    input  wire logic                   SYNC_PIN_B_I,
    input  wire vst_pkg::vst_sample_type VIDEO_IN,
    output vst_pkg::vst_sample_type     VIDEO_OUT,
    output logic                        HSYNC_OUT,
    output logic                        VBLANK_OUT,
    output logic                        FIELD_EVEN_OUT,
    output logic                        SC_PHASE_RESET,
    output logic                        FIELD_SEQUENCE_PULSE_MISMATCH
);
    logic [7:0]  horiz_trigger_phase_lo_reg;
    logic [7:0]  horiz_trigger_phase_vtrg_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  rdata_reg;
    logic [10:0] horiz_trigger_phase;
    logic [9:0]  vert_trigger_phase;
    logic        sblank;
    logic        fblank;
    logic [1:0]  subcarrier_phase_reset_mode;
    logic [1:0]  luma_delay_select;
    logic [1:0]  flen_sel;
    vst_pkg::vst_sync_type_type sync_type;

    logic [2:0]  pin_rise;
    logic [2:0]  pin_fall;
    logic        a_edge;
    logic        b_edge;
    logic        rtc_edge;
    logic        h_edge;
    logic        v_edge;

    logic [10:0] h_cnt_reg;
    logic [10:0] line_len;
    logic [9:0]  flen;
    logic        half_tick;
    logic        line_tick;
    logic        field_end;
    logic [9:0]  fh_cnt_reg;
    logic [8:0]  line_in_field;
    logic        field_even_reg;
    logic [3:0]  seq_cnt_reg;
    logic [3:0]  seq_len;
    logic [2:0]  field_mod8_reg;
    logic        mismatch_reg;
    logic        hsync_reg;
    logic        vblank_reg;
    logic        sc_reset_next;
    logic        sc_reset_reg;
    logic        pin_a_level;
    logic        pin_a_o_reg;
    logic        blank_now;
    logic [7:0]  luma_dly;
    logic [7:0]  chroma_reg;
    vst_pkg::vst_sample_type video_out_reg;

    // register port: byte writes at the three subaddresses
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            horiz_trigger_phase_lo_reg   <= vst_pkg::HORIZ_TRIGGER_PHASE_LO_RESET;
            horiz_trigger_phase_vtrg_reg <= vst_pkg::HORIZ_TRIGGER_PHASE_VTRG_RESET;
            ctrl_reg       <= vst_pkg::CTRL_RESET;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                vst_pkg::ADDR_HORIZ_TRIGGER_PHASE_LO:   horiz_trigger_phase_lo_reg   <= REG_WDATA;
                vst_pkg::ADDR_HORIZ_TRIGGER_PHASE_VTRG: horiz_trigger_phase_vtrg_reg <= REG_WDATA;
                vst_pkg::ADDR_CTRL:       ctrl_reg       <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // read data is registered; unmapped subaddresses read as zero
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rdata_reg <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                vst_pkg::ADDR_HORIZ_TRIGGER_PHASE_LO:   rdata_reg <= horiz_trigger_phase_lo_reg;
                vst_pkg::ADDR_HORIZ_TRIGGER_PHASE_VTRG: rdata_reg <= horiz_trigger_phase_vtrg_reg;
                vst_pkg::ADDR_CTRL:       rdata_reg <= ctrl_reg;
                default:                  rdata_reg <= 8'h00;
            endcase
        end
    end
    assign REG_RDATA = rdata_reg;

    // field decode
    assign horiz_trigger_phase = {horiz_trigger_phase_vtrg_reg[7:vst_pkg::HORIZ_TRIGGER_PHASE_HI_LSB],
                    horiz_trigger_phase_lo_reg};
    assign vert_trigger_phase = {5'h00, horiz_trigger_phase_vtrg_reg[vst_pkg::VERT_TRIGGER_PHASE_MSB:0]};
    assign sblank   = ctrl_reg[vst_pkg::CTRL_SBLANK];
    assign fblank   = ctrl_reg[vst_pkg::CTRL_FBLANK];
    assign subcarrier_phase_reset_mode    = ctrl_reg[vst_pkg::CTRL_SUBCARRIER_PHASE_RESET_MODE +: 2];
    assign luma_delay_select     = ctrl_reg[vst_pkg::CTRL_LUMA_DELAY_SELECT +: 2];
    assign flen_sel = ctrl_reg[vst_pkg::CTRL_FLEN +: 2];
    // undefined code 3 falls back to the per-field default
    assign sync_type = (SYNC_A_TYPE == 2'h3) ?
        vst_pkg::SYNC_VERT_PER_FIELD :
        vst_pkg::vst_sync_type_type'(SYNC_A_TYPE);

    vst_pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .pin   ({REALTIME_CONTROL_INPUT, SYNC_PIN_B_I, SYNC_PIN_A_I}),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    // pin A edges only count while it is an input
    assign a_edge = !SYNC_A_DIRECTION &&
        (SYNC_A_POLARITY ? pin_fall[0] : pin_rise[0]);
    assign b_edge   = pin_rise[1];
    assign rtc_edge = pin_rise[2];
    // embedded sync decoding lives elsewhere; pin A then stays in use
    assign h_edge = (HORIZ_SOURCE_SELECT && !EMBEDDED_SYNC_MODE) ?
        b_edge : a_edge;
    assign v_edge = a_edge;

    // horizontal counter; loading the phase moves every internal event
    assign line_len = FIELD_RATE_SELECT ? vst_pkg::LINE_LEN_60
                                        : vst_pkg::LINE_LEN_50;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            h_cnt_reg <= 11'h000;
        end else if (h_edge) begin
            h_cnt_reg <= horiz_trigger_phase;
        end else if (h_cnt_reg >= line_len - 11'h001) begin
            // out-of-range phases simply wrap on the next clock
            h_cnt_reg <= 11'h000;
        end else begin
            h_cnt_reg <= h_cnt_reg + 11'h001;
        end
    end

    assign line_tick = (h_cnt_reg == 11'h000);
    assign half_tick = line_tick || (h_cnt_reg == {1'b0, line_len[10:1]});

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            hsync_reg <= 1'b0;
        end else begin
            hsync_reg <= (h_cnt_reg == vst_pkg::HSYNC_LEAD);
        end
    end
    assign HSYNC_OUT = hsync_reg;

    // field length in half lines
    always_comb begin
        unique case (flen_sel)
            2'h1: flen = FIELD_RATE_SELECT ? vst_pkg::FLEN_60_SHRT
                                           : vst_pkg::FLEN_50_SHRT;
            2'h2: flen = FIELD_RATE_SELECT ? vst_pkg::FLEN_60_LONG
                                           : vst_pkg::FLEN_50_LONG;
            default: flen = FIELD_RATE_SELECT ? vst_pkg::FLEN_60_INTL
                                              : vst_pkg::FLEN_50_INTL;
        endcase
    end
    assign field_end = half_tick && (fh_cnt_reg >= flen - 10'h001);

    // half-line counter within the field
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            fh_cnt_reg <= 10'h000;
        end else if (v_edge) begin
            fh_cnt_reg <= vert_trigger_phase;
        end else if (field_end) begin
            fh_cnt_reg <= 10'h000;
        end else if (half_tick) begin
            fh_cnt_reg <= fh_cnt_reg + 10'h001;
        end
    end
    assign line_in_field = fh_cnt_reg[9:1];

    // field parity and sequence position
    assign seq_len = SECAM_SELECT ? vst_pkg::SEQ_LEN_SECAM :
                     PAL_SEQUENCE ? vst_pkg::SEQ_LEN_PAL :
                                    vst_pkg::SEQ_LEN_BASE;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            field_even_reg <= 1'b0;
            seq_cnt_reg    <= 4'h0;
        end else if (v_edge &&
                     sync_type != vst_pkg::SYNC_VERT_PER_FIELD) begin
            // frame and sequence references mark the odd field start
            field_even_reg <= 1'b0;
            if (sync_type == vst_pkg::SYNC_FIELD_SEQUENCE) begin
                seq_cnt_reg <= 4'h0;
            end
        end else if (field_end) begin
            field_even_reg <= !field_even_reg;
            seq_cnt_reg <= (seq_cnt_reg >= seq_len - 4'h1) ?
                           4'h0 : seq_cnt_reg + 4'h1;
        end
    end
    assign FIELD_EVEN_OUT = field_even_reg;

    // a sequence reference away from the expected field is flagged
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mismatch_reg <= 1'b0;
        end else begin
            mismatch_reg <= v_edge &&
                sync_type == vst_pkg::SYNC_FIELD_SEQUENCE &&
                !(seq_cnt_reg == 4'h0 && fh_cnt_reg <= vert_trigger_phase + 10'h002);
        end
    end
    assign FIELD_SEQUENCE_PULSE_MISMATCH = mismatch_reg;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            field_mod8_reg <= 3'h0;
        end else if (field_end) begin
            field_mod8_reg <= field_mod8_reg + 3'h1;
        end
    end

    // subcarrier phase reset cadence
    always_comb begin
        unique case (subcarrier_phase_reset_mode)
            2'h0: sc_reset_next = REALTIME_CONTROL_ENABLE && rtc_edge;
            2'h1: sc_reset_next = line_tick &&
                      (SECAM_SELECT || !line_in_field[0]);
            2'h2: sc_reset_next = field_end && field_mod8_reg == 3'h7;
            2'h3: sc_reset_next = field_end && field_mod8_reg[1:0] == 2'h3;
        endcase
    end
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sc_reset_reg <= 1'b0;
        end else begin
            sc_reset_reg <= sc_reset_next;
        end
    end
    assign SC_PHASE_RESET = sc_reset_reg;

    // vertical blanking
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            vblank_reg <= 1'b1;
        end else if (sblank) begin
            vblank_reg <= FIELD_RATE_SELECT ?
                (line_in_field < vst_pkg::STD60_FIRST ||
                 line_in_field > vst_pkg::STD60_LAST) :
                (line_in_field < vst_pkg::STD50_FIRST ||
                 line_in_field > vst_pkg::STD50_LAST);
        end else begin
            vblank_reg <= line_in_field < FIRST_ACTIVE_LINE ||
                          line_in_field > LAST_ACTIVE_LINE;
        end
    end
    assign VBLANK_OUT = vblank_reg;

    // pin A as output: sync form follows the selected type
    always_comb begin
        unique case (sync_type)
            vst_pkg::SYNC_ODD_EVEN_FRAME:
                pin_a_level = !field_even_reg;
            vst_pkg::SYNC_FIELD_SEQUENCE:
                pin_a_level = seq_cnt_reg == 4'h0 &&
                              fh_cnt_reg < vst_pkg::VSYNC_HALF_LINES;
            default:
                pin_a_level = fh_cnt_reg < vst_pkg::VSYNC_HALF_LINES;
        endcase
    end
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pin_a_o_reg <= 1'b0;
        end else begin
            pin_a_o_reg <= pin_a_level ^ SYNC_A_POLARITY;
        end
    end
    assign SYNC_PIN_A_O  = pin_a_o_reg;
    assign SYNC_PIN_A_OE = SYNC_A_DIRECTION;

    // video path: luma delayed against a one-register chroma path
    vst_luma_delay #(
        .WIDTH (8)
    ) u_luma_delay (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .sel   (luma_delay_select),
        .din   (VIDEO_IN.luma),
        .dout  (luma_dly)
    );
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            chroma_reg <= vst_pkg::BLANK_CHROMA;
        end else begin
            chroma_reg <= VIDEO_IN.chroma;
        end
    end

    // forced blanking wins over everything; it is on from reset
    assign blank_now = fblank || vblank_reg;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            video_out_reg.luma   <= vst_pkg::BLANK_LUMA;
            video_out_reg.chroma <= vst_pkg::BLANK_CHROMA;
        end else if (blank_now) begin
            video_out_reg.luma   <= vst_pkg::BLANK_LUMA;
            video_out_reg.chroma <= vst_pkg::BLANK_CHROMA;
        end else begin
            video_out_reg.luma   <= luma_dly;
            video_out_reg.chroma <= chroma_reg;
        end
    end
    assign VIDEO_OUT = video_out_reg;

    chk_reset_defaults : assert property (
        @(posedge REF_CLK) $rose(RST_N) |->
        ctrl_reg == vst_pkg::CTRL_RESET && horiz_trigger_phase_lo_reg == 8'h00)
        else $error("control register not at default after reset");

    chk_horiz_trigger_phase_load : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        h_edge |=> h_cnt_reg == $past(horiz_trigger_phase))
        else $error("horizontal phase not loaded on trigger edge");

    chk_hsync_mark : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (h_edge && horiz_trigger_phase == 11'h04f) |=> ##1 hsync_reg)
        else $error("hsync lead not aligned at phase 79");

    chk_vert_trigger_phase_load : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        v_edge |=> fh_cnt_reg == $past(vert_trigger_phase))
        else $error("vertical phase not loaded on reference");

    chk_field_wrap : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (field_end && !v_edge) |=> fh_cnt_reg == 10'h000)
        else $error("field did not wrap at its length");

    chk_short_field : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (flen_sel == 2'h1 && !FIELD_RATE_SELECT) |-> flen == 10'h270)
        else $error("312 line field length wrong");

    chk_long_field : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (flen_sel == 2'h2 && !FIELD_RATE_SELECT) |-> flen == 10'h272)
        else $error("313 line field length wrong");

    chk_force_blank : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        fblank |=> VIDEO_OUT.luma == vst_pkg::BLANK_LUMA &&
                   VIDEO_OUT.chroma == vst_pkg::BLANK_CHROMA)
        else $error("output not held at blanking level");

    chk_subcarrier_phase_reset_mode_none : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (subcarrier_phase_reset_mode == 2'h0 && !REALTIME_CONTROL_ENABLE) |=> !sc_reset_reg)
        else $error("phase reset without a source");

    chk_subcarrier_phase_reset_mode_lines : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (subcarrier_phase_reset_mode == 2'h1 && line_tick && !line_in_field[0]) |=> sc_reset_reg)
        else $error("two-line phase reset missed");

    chk_pin_a_hold : assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (SYNC_A_DIRECTION && !HORIZ_SOURCE_SELECT) |-> !h_edge && !v_edge)
        else $error("output pin A used as trigger");

    cov_h_trigger : cover property (
        @(posedge REF_CLK) disable iff (!RST_N) h_edge ##[1:3] hsync_reg);
    cov_field_end : cover property (
        @(posedge REF_CLK) disable iff (!RST_N) field_end && field_even_reg);
    cov_unblank : cover property (
        @(posedge REF_CLK) disable iff (!RST_N) $fell(fblank));
endmodule

// ### core/vst_pkg.sv
// package for the video sync trigger timing block
// assumes one line-locked pixel clock and byte-wide register writes
package vst_pkg;
    // register subaddresses
    localparam logic [7:0] ADDR_HORIZ_TRIGGER_PHASE_LO   = 8'h6c;
    localparam logic [7:0] ADDR_HORIZ_TRIGGER_PHASE_VTRG = 8'h6d;
    localparam logic [7:0] ADDR_CTRL       = 8'h6e;
    // reset values
    localparam logic [7:0] HORIZ_TRIGGER_PHASE_LO_RESET   = 8'h00;
    localparam logic [7:0] HORIZ_TRIGGER_PHASE_VTRG_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET       = 8'h40;
    // field positions
    localparam int HORIZ_TRIGGER_PHASE_HI_LSB = 5;
    localparam int VERT_TRIGGER_PHASE_MSB    = 4;
    localparam int CTRL_SBLANK  = 7;
    localparam int CTRL_FBLANK  = 6;
    localparam int CTRL_SUBCARRIER_PHASE_RESET_MODE   = 4;
    localparam int CTRL_LUMA_DELAY_SELECT    = 2;
    localparam int CTRL_FLEN    = 0;
    // line lengths in pixel clocks, by field rate select
    localparam logic [10:0] LINE_LEN_50 = 11'h6c0;
    localparam logic [10:0] LINE_LEN_60 = 11'h6b4;
    // field lengths in half lines
    localparam logic [9:0] FLEN_50_INTL = 10'h271;
    localparam logic [9:0] FLEN_50_SHRT = 10'h270;
    localparam logic [9:0] FLEN_50_LONG = 10'h272;
    localparam logic [9:0] FLEN_60_INTL = 10'h20d;
    localparam logic [9:0] FLEN_60_SHRT = 10'h20c;
    localparam logic [9:0] FLEN_60_LONG = 10'h20e;
    // counter value that marks the leading slope of horizontal sync
    localparam logic [10:0] HSYNC_LEAD = 11'h04f;
    // vertical sync output width in half lines
    localparam logic [9:0] VSYNC_HALF_LINES = 10'h006;
    // standard active line windows (line within field)
    localparam logic [8:0] STD50_FIRST = 9'h017;
    localparam logic [8:0] STD50_LAST  = 9'h136;
    localparam logic [8:0] STD60_FIRST = 9'h014;
    localparam logic [8:0] STD60_LAST  = 9'h106;
    // blanking levels
    localparam logic [7:0] BLANK_LUMA   = 8'h10;
    localparam logic [7:0] BLANK_CHROMA = 8'h80;
    // field sequence lengths
    localparam logic [3:0] SEQ_LEN_BASE  = 4'h4;
    localparam logic [3:0] SEQ_LEN_PAL   = 4'h8;
    localparam logic [3:0] SEQ_LEN_SECAM = 4'hc;

    typedef enum logic [1:0] {
        SYNC_VERT_PER_FIELD = 2'h0,
        SYNC_ODD_EVEN_FRAME = 2'h1,
        SYNC_FIELD_SEQUENCE = 2'h2,
        SYNC_UNDEFINED      = 2'h3
    } vst_sync_type_type;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
    } vst_sample_type;
endpackage

// ### core/vst_pin_sync.sv
// three-flop synchronisers with agreed-level edge detection
// assumes pins are asynchronous to REF_CLK
module vst_pin_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // per-bit flops keep each variable owned by one process
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic level_reg;
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                s1_reg    <= 1'b0;
                s2_reg    <= 1'b0;
                s3_reg    <= 1'b0;
                level_reg <= 1'b0;
            end else begin
                s1_reg <= pin[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                // a change counts only once stages two and three agree
                if (s2_reg == s3_reg) begin
                    level_reg <= s3_reg;
                end
            end
        end
        assign rise[i] = (s2_reg == s3_reg) && s3_reg && !level_reg;
        assign fall[i] = (s2_reg == s3_reg) && !s3_reg && level_reg;
    end
endmodule

// ### core/vst_luma_delay.sv
// selectable luma delay of 0 to 3 extra pixel clocks
// assumes the chroma path carries one fixed register to match
module vst_luma_delay #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [1:0]       sel,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] tap_reg [3];
    logic [WIDTH-1:0] out_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tap_reg[0] <= '0;
            tap_reg[1] <= '0;
            tap_reg[2] <= '0;
            out_reg    <= '0;
        end else begin
            tap_reg[0] <= din;
            tap_reg[1] <= tap_reg[0];
            tap_reg[2] <= tap_reg[1];
            out_reg <= (sel == 2'h0) ? din : tap_reg[sel - 2'h1];
        end
    end
    assign dout = out_reg;

    chk_luma_one_clock : assert property (
        @(posedge clk) disable iff (!rst_n)
        (sel == 2'h1)[*3] |-> out_reg == $past(din, 2))
        else $error("luma delay of one clock not seen");
endmodule

// ### testbench/vst_src.sv
// upstream sync source: free-running line reference on both sync pins
// assumes its clock is the pixel clock and a 1728-clock line
module vst_src #(
    parameter int LINE = 1728
) (
    input  wire logic clk,
    output logic      pin_a,
    output logic      pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial {pin_a, pin_b} = 2'b00;
    // pin b is offset so a wrong trigger source shows up as a delay error
    always @(negedge clk) begin
        cnt = (cnt + 1) % LINE;
        pin_a <= cnt < 64;
        pin_b <= cnt >= 800 && cnt < 864;
    end
endmodule

// ### testbench/tb_vst_timing.sv
// self-checking bench for the sync trigger timing block
// assumes the vst_src partner and 50 Hz line length
module tb_vst_timing;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
    logic pol = 1'b0, hsel = 1'b0, pa, pb, hs, oe;
    logic dir = 1'b0, rte = 1'b0, rti = 1'b0, pao, vb, sc;
    logic [8:0] first_active_line = 9'h000, last_active_line = 9'h1ff;
    vst_pkg::vst_sample_type vin = {8'h20, 8'h80}, vout;
    int bad_count = 0, check_count = 0, d0, d1, dl, dc;
    wire trig = (hsel ? pb : pa) ^ pol;
    always #20 ref_clk = ~ref_clk;
    vst_src vst_src_inst (.clk(ref_clk), .pin_a(pa), .pin_b(pb));
    vst_timing vst_timing_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .SYNC_A_TYPE(2'h0),
        .SYNC_A_POLARITY(pol), .SYNC_A_DIRECTION(dir),
        .HORIZ_SOURCE_SELECT(hsel), .EMBEDDED_SYNC_MODE(1'b0),
        .FIELD_RATE_SELECT(1'b0), .PAL_SEQUENCE(1'b0), .SECAM_SELECT(1'b0),
        .REALTIME_CONTROL_ENABLE(rte), .REALTIME_CONTROL_INPUT(rti),
        .FIRST_ACTIVE_LINE(first_active_line), .LAST_ACTIVE_LINE(last_active_line),
        .SYNC_PIN_A_I(pa), .SYNC_PIN_A_O(pao), .SYNC_PIN_A_OE(oe),
        .SYNC_PIN_B_I(pb), .VIDEO_IN(vin), .VIDEO_OUT(vout),
        .HSYNC_OUT(hs), .VBLANK_OUT(vb), .FIELD_EVEN_OUT(),
        .SC_PHASE_RESET(sc), .FIELD_SEQUENCE_PULSE_MISMATCH());
    task automatic conclude;
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge ref_clk);
        {wr, addr, wdata} = {1'b1, a, d};
        @(negedge ref_clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        @(negedge ref_clk);
        {rd, addr} = {1'b1, a};
        @(negedge ref_clk);
        rd = 1'b0;
        @(negedge ref_clk);
        check("reg", {8'h00, rdata}, {8'h00, exp});
    endtask
    // clocks from the active trigger edge to the horizontal sync pulse
    task automatic hs_delay(output int d);
        int t, u;
        for (t = 0; t < 4000 && trig !== 1'b0; t++) @(negedge ref_clk);
        for (u = 0; u < 4000 && trig !== 1'b1; u++) @(negedge ref_clk);
        for (d = 0; d < 4000 && hs !== 1'b1; d++) @(negedge ref_clk);
        if (t >= 4000 || u >= 4000 || d >= 4000) begin
            bad_count++;
            conclude();
        end
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        rd_chk(8'h6c, 8'h00);
        rd_chk(8'h6e, 8'h40);
        rd_chk(8'h00, 8'h00);
        check("blank", vout, 16'h1080);
        check("pin a oe", {15'h0, oe}, 16'h0000);
        wr_reg(8'h6e, 8'h00);
        repeat (4) @(negedge ref_clk);
        check("unblank", vout, vin);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h6e, 8'((k << 2) | (k % 3)));
            repeat (6) @(negedge ref_clk);
            vin = {8'(k + 8'h30), 8'(k + 8'h40)};
            for (dc = 0; dc < 20 && vout.chroma !== vin.chroma; dc++)
                @(negedge ref_clk);
            for (dl = dc; dl < 20 && vout.luma !== vin.luma; dl++)
                @(negedge ref_clk);
            check("luma delay", 16'(dl - dc), 16'(k));
            check("chroma path", 16'(dc), 16'd2);
        end
        // mode 0 with the enable set: one reset per input rise
        rte = 1'b1;
        rti = 1'b1;
        for (dc = 0; dc < 10 && sc !== 1'b1; dc++) @(negedge ref_clk);
        check("rtc reset", 16'(dc), 16'd4);
        // phases stay inside the 1728-clock line
        wr_reg(8'h6c, 8'h4f);
        wr_reg(8'h6d, 8'ha0);
        rd_chk(8'h6d, 8'ha0);
        hs_delay(d0);
        hs_delay(d0);
        check("phase high bits", 16'(d0), 16'd452);
        wr_reg(8'h6c, 8'h50);
        hs_delay(d1);
        hs_delay(d1);
        check("phase step", 16'(d0 - d1), 16'd1);
        wr_reg(8'h6c, 8'h4f);
        wr_reg(8'h6d, 8'h00);
        hs_delay(d0);
        hs_delay(d0);
        check("phase 79", 16'(d0), 16'd4);
        hsel = 1'b1;
        hs_delay(d0);
        hs_delay(d0);
        check("pin b trigger", 16'(d0), 16'd4);
        {hsel, pol} = 2'b01;
        hs_delay(d0);
        hs_delay(d0);
        check("falling trigger", 16'(d0), 16'd4);
        // each line reference reloads the field count, so lines stay low
        first_active_line = 9'h002;
        repeat (3) @(negedge ref_clk);
        check("vblank first", {15'h0, vb}, 16'h0001);
        wr_reg(8'h6e, 8'h10);
        wr_reg(8'h6d, 8'h1f);
        {first_active_line, last_active_line} = {9'h000, 9'h00a};
        repeat (3500) @(negedge ref_clk);
        check("vblank last", {15'h0, vb}, 16'h0001);
        dir = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("pin a out", {14'h0, oe, pao}, 16'h0003);
        conclude();
    end
endmodule
